/* File: ext_mem_ctrl.sv */
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// - Muxed low address/data, high address, latch, strobes
// - Enabled interface overrides bus pin directions
// - Only external addresses get read/write strobe activity
// - Low address valid when latch strobe falls
// - Latch strobe low through whole data phase
// - Internal access never pulses read/write strobe
// - Disabled: port pins, no aliasing above boundary
// - Pull-ups where port output bit is one
// - Keeper holds last value while bus tri-stated
// - Four selectable wait-state settings
// - Lower and upper sectors, own wait settings
// - Trailing latch pulse only if next accesses memory
// - Enable bit 7 activates bus, clear disables
// - Upper wait split over two registers
// - Limit zero: all external space upper sector
// - Upper sector starts at k times 0x2000
// - Wait codes zero, one, two, two plus hold
// - Keeper enable independent of interface enable
// - High mask releases top address pins
module ext_mem_ctrl
  import ext_mem_pkg::*;
#(
  parameter logic [15:0] INT_TOP = INT_TOP_RST
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone register slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Core data-space port
  input  wire logic        req_i,
  input  wire mem_req_s    req_data_i,
  input  wire logic        next_mem_i,
  output logic             done_o,
  output logic             ext_hit_o,
  output logic      [7:0]  rdata_o,
  // Port registers behind the bus pins
  input  wire port_cfg_s   port_ad_i,
  input  wire port_cfg_s   port_ah_i,
  // Multiplexed low address/data pins
  input  wire logic [7:0]  ad_i,
  output logic      [7:0]  ad_o,
  output logic      [7:0]  ad_oe_o,
  output logic      [7:0]  ad_pullup_o,
  output logic      [7:0]  ad_keep_val_o,
  output logic             ad_keep_en_o,
  // High address pins
  output logic      [7:0]  ah_o,
  output logic      [7:0]  ah_oe_o,
  // Control strobes
  output logic             ctrl_pins_en_o,
  output logic             ale_o,
  output logic             rd_n_o,
  output logic             wr_n_o
);

  if (INT_TOP >= EXT_BASE) begin : g_chk
    $error("INT_TOP must lie below the external base");
  end

  // Strobe cycles beyond the first for a wait code
  function automatic logic [1:0] strobe_extra(input logic [1:0] code);
    unique case (code)
      WAIT_NONE: strobe_extra = 2'h0;
      WAIT_ONE:  strobe_extra = 2'h1;
      WAIT_TWO:  strobe_extra = 2'h2;
      WAIT_TWO_HOLD: strobe_extra = 2'h2;
    endcase
  endfunction : strobe_extra

  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [7:0] special_q;

  bus_state_e state_q;
  bus_state_e state_d;
  logic [1:0] wait_q;
  logic [1:0] code_q;
  logic       upper_q;
  logic       ext_q;
  mem_req_s   req_q;

  logic       enable;
  logic       keeper_en;
  logic [2:0] limit;
  logic [2:0] hmask;
  logic [1:0] upper_code;
  logic [1:0] lower_code;
  logic [15:0] upper_start;
  logic       is_ext;
  logic       is_upper;
  logic       strobe_last;
  logic       finish;
  logic       take;
  mem_req_s   cur_req;

  assign enable     = ctrl_a_q[POS_EXT_BUS_ENABLE];
  assign keeper_en  = special_q[POS_BUS_KEEPER];
  assign limit      = ctrl_b_q[POS_SECTOR_LIMIT_LO +: 3];
  assign hmask      = special_q[POS_HIGH_MASK_LO +: 3];
  assign upper_code = {ctrl_b_q[POS_UPPER_WAIT_HI],
                       ctrl_a_q[POS_UPPER_WAIT_LO]};
  assign lower_code = ctrl_b_q[POS_LOWER_WAIT_LO +: 2];

  // Upper start is k * 0x2000; k = 0 leaves no lower sector
  assign upper_start = {limit, 13'h0000};
  assign is_ext   = enable && (req_data_i.addr > INT_TOP);
  assign is_upper = (limit == 3'h0) ||
                    (req_data_i.addr >= upper_start);
  assign strobe_last = (wait_q == 2'h0);
  // Refused while done_o stands, so a held request is not taken twice
  assign take    = (state_q == ST_IDLE) && req_i && !done_o;
  // Launch cycle drives the address before req_q holds it
  assign cur_req = (state_q == ST_IDLE) ? req_data_i : req_q;

  // Wishbone slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_a_q  <= CTRL_A_RST;
      ctrl_b_q  <= CTRL_B_RST;
      special_q <= SPECIAL_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                 wb_sel_i[0]) begin
      unique case (wb_adr_i)
        OFS_CTRL_A:  ctrl_a_q  <= wb_dat_i[7:0];
        OFS_CTRL_B:  ctrl_b_q  <= wb_dat_i[7:0];
        OFS_SPECIAL: special_q <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      unique case (wb_adr_i)
        OFS_CTRL_A:  wb_dat_o <= {24'h00_0000, ctrl_a_q};
        OFS_CTRL_B:  wb_dat_o <= {24'h00_0000, ctrl_b_q};
        OFS_SPECIAL: wb_dat_o <= {24'h00_0000, special_q};
        OFS_STATUS:  wb_dat_o <= {24'h00_0000, ext_q, upper_q,
                                  code_q, 1'b0, state_q};
        default:     wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Access sequencer
  always_comb begin
    state_d = state_q;
    finish  = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (take) begin
          if (enable) begin
            state_d = ST_ADDR;
          end else begin
            finish = 1'b1;
          end
        end
      end
      ST_ADDR: begin
        state_d = ST_LATCH;
      end
      ST_LATCH: begin
        if (ext_q) begin
          state_d = ST_STROBE;
        end else begin
          finish  = 1'b1;
          state_d = next_mem_i ? ST_TRAIL : ST_IDLE;
        end
      end
      ST_STROBE: begin
        if (strobe_last) begin
          if (code_q == WAIT_TWO_HOLD) begin
            state_d = ST_HOLD;
          end else begin
            finish  = 1'b1;
            state_d = next_mem_i ? ST_TRAIL : ST_IDLE;
          end
        end
      end
      ST_HOLD: begin
        finish  = 1'b1;
        state_d = next_mem_i ? ST_TRAIL : ST_IDLE;
      end
      ST_TRAIL: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Request capture, sector and wait code decided before strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q   <= '0;
      ext_q   <= 1'b0;
      upper_q <= 1'b0;
      code_q  <= WAIT_NONE;
    end else if (take) begin
      req_q   <= req_data_i;
      ext_q   <= is_ext;
      upper_q <= is_upper;
      code_q  <= is_upper ? upper_code : lower_code;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q <= 2'h0;
    end else if (state_q == ST_LATCH) begin
      wait_q <= strobe_extra(code_q);
    end else if (state_q == ST_STROBE && !strobe_last) begin
      wait_q <= wait_q - 2'h1;
    end
  end

  // Core answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o    <= 1'b0;
      ext_hit_o <= 1'b0;
      rdata_o   <= 8'h00;
    end else begin
      done_o <= finish;
      if (finish) begin
        ext_hit_o <= (state_q != ST_IDLE) && ext_q;
      end
      // Data sampled at the last strobe cycle, before rising edge
      if (state_q == ST_STROBE && strobe_last && !req_q.we) begin
        rdata_o <= ad_i;
      end else if (take && !enable) begin
        rdata_o <= 8'h00;
      end
    end
  end

  // Strobes from the next state so they leave flops directly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ale_o  <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
    end else begin
      ale_o  <= enable && (state_d == ST_ADDR ||
                           state_d == ST_TRAIL);
      rd_n_o <= !(state_d == ST_STROBE && !req_q.we);
      wr_n_o <= !(state_d == ST_STROBE && req_q.we);
    end
  end

  // Pin muxing between interface and port
  logic [7:0] ad_bus_val;
  logic       ad_bus_drv;
  logic [7:0] ah_own;
  logic [3:0] released;

  always_comb begin
    ad_bus_drv = 1'b0;
    ad_bus_val = ad_o;
    unique case (state_d)
      ST_ADDR, ST_LATCH: begin
        ad_bus_drv = 1'b1;
        ad_bus_val = cur_req.addr[7:0];
      end
      ST_STROBE, ST_HOLD: begin
        ad_bus_drv = req_q.we;
        ad_bus_val = req_q.wdata;
      end
      default: ;
    endcase
  end

  // Mask code m releases m top pins, 111 releases all eight
  assign released = (hmask == 3'h7) ? 4'h8 : {1'b0, hmask};
  assign ah_own   = 8'hff >> released;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ad_o           <= 8'h00;
      ad_oe_o        <= 8'h00;
      ah_o           <= 8'h00;
      ah_oe_o        <= 8'h00;
      ctrl_pins_en_o <= 1'b0;
    end else begin
      ctrl_pins_en_o <= enable;
      if (enable) begin
        ad_o    <= ad_bus_val;
        ad_oe_o <= {8{ad_bus_drv}};
        ah_o    <= (cur_req.addr[15:8] & ah_own) |
                   (port_ah_i.out_val & ~ah_own);
        ah_oe_o <= ah_own | (port_ah_i.dir & ~ah_own);
      end else begin
        ad_o    <= port_ad_i.out_val;
        ad_oe_o <= port_ad_i.dir;
        ah_o    <= port_ah_i.out_val;
        ah_oe_o <= port_ah_i.dir;
      end
    end
  end

  // Pull-ups follow port output bits on undriven lines
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ad_pullup_o <= 8'h00;
    end else if (enable) begin
      ad_pullup_o <= port_ad_i.out_val & ~{8{ad_bus_drv}};
    end else begin
      ad_pullup_o <= port_ad_i.out_val & ~port_ad_i.dir;
    end
  end

  // Keeper: not gated by the interface enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ad_keep_val_o <= 8'h00;
      ad_keep_en_o  <= 1'b0;
    end else begin
      ad_keep_en_o <= keeper_en &&
                      (enable ? !ad_bus_drv : 1'b1);
      if (ad_oe_o != 8'h00) begin
        ad_keep_val_o <= (ad_o & ad_oe_o) |
                         (ad_keep_val_o & ~ad_oe_o);
      end else begin
        ad_keep_val_o <= ad_keep_val_o;
      end
    end
  end

endmodule : ext_mem_ctrl

/* File: ext_mem_ctrl_properties.sv */
`timescale 1ns/1ns
module ext_mem_ctrl_properties
  import ext_mem_pkg::*;
#(
  parameter logic [15:0] INT_TOP = INT_TOP_RST
) (
  // Clock, reset, register bus
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // Core port
  input wire logic       req_i,
  input wire mem_req_s   req_data_i,
  input wire logic       next_mem_i,
  input wire logic       done_o,
  // Pins
  input wire logic [7:0] ad_o,
  input wire logic [7:0] ad_oe_o,
  input wire logic       ctrl_pins_en_o,
  input wire logic       ale_o,
  input wire logic       rd_n_o,
  input wire logic       wr_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire strobe = !rd_n_o || !wr_n_o;
  sequence s_addr_lo;
    ad_oe_o == 8'hff && ad_o == req_data_i.addr[7:0];
  endsequence
  property p_ale_addr; $fell(ale_o) && req_i |-> s_addr_lo; endproperty
  a_ale_addr: assert property (p_ale_addr)
    else $error("low address not valid at latch fall");
  property p_ale_low; strobe |-> !ale_o; endproperty
  a_ale_low: assert property (p_ale_low)
    else $error("latch strobe high in data phase");
  property p_ext_only;
    strobe |-> req_i && ctrl_pins_en_o && req_data_i.addr > INT_TOP;
  endproperty
  a_ext_only: assert property (p_ext_only)
    else $error("strobe without external access");
  property p_wr_data;
    !wr_n_o |-> ad_oe_o == 8'hff && ad_o == req_data_i.wdata;
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write data not driven");
  property p_off; !ctrl_pins_en_o |-> rd_n_o && wr_n_o; endproperty
  a_off: assert property (p_off)
    else $error("strobe while disabled");
  property p_len; $fell(rd_n_o) |-> ##[1:3] rd_n_o; endproperty
  a_len: assert property (p_len)
    else $error("read strobe too long");
  property p_trail; done_o && !next_mem_i |-> !ale_o ##1 !ale_o; endproperty
  a_trail: assert property (p_trail)
    else $error("trailing latch pulse without next access");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("register ack timing");
  property p_rst;
    disable iff (1'b0) rst_i |=> rd_n_o && wr_n_o && !done_o && !wb_ack_o;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs active after reset");
endmodule : ext_mem_ctrl_properties

bind ext_mem_ctrl ext_mem_ctrl_properties #(.INT_TOP(INT_TOP)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .req_i(req_i), .req_data_i(req_data_i),
  .next_mem_i(next_mem_i), .done_o(done_o), .ad_o(ad_o), .ad_oe_o(ad_oe_o),
  .ctrl_pins_en_o(ctrl_pins_en_o), .ale_o(ale_o), .rd_n_o(rd_n_o),
  .wr_n_o(wr_n_o));

/* File: ext_mem_pkg.sv */
package ext_mem_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [3:0] OFS_CTRL_A   = 4'h0;
  localparam logic [3:0] OFS_CTRL_B   = 4'h4;
  localparam logic [3:0] OFS_SPECIAL  = 4'h8;
  localparam logic [3:0] OFS_STATUS   = 4'hc;

  // Reset values
  localparam logic [7:0] CTRL_A_RST   = 8'h00;
  localparam logic [7:0] CTRL_B_RST   = 8'h00;
  localparam logic [7:0] SPECIAL_RST  = 8'h00;

  // system_control_a fields
  localparam int POS_EXT_BUS_ENABLE   = 7;
  localparam int POS_UPPER_WAIT_LO    = 6;
  // system_control_b fields
  localparam int POS_SECTOR_LIMIT_LO  = 4;
  localparam int POS_LOWER_WAIT_LO    = 2;
  localparam int POS_UPPER_WAIT_HI    = 1;
  // special_function_control fields
  localparam int POS_BUS_KEEPER       = 6;
  localparam int POS_HIGH_MASK_LO     = 3;

  // Address map of the external space
  localparam logic [15:0] EXT_BASE      = 16'h1100;
  localparam logic [15:0] SECTOR_STEP   = 16'h2000;
  localparam logic [15:0] INT_TOP_RST   = 16'h04ff;

  // Wait codes
  localparam logic [1:0] WAIT_NONE      = 2'h0;
  localparam logic [1:0] WAIT_ONE       = 2'h1;
  localparam logic [1:0] WAIT_TWO       = 2'h2;
  localparam logic [1:0] WAIT_TWO_HOLD  = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_LATCH  = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD   = 3'b100,
    ST_TRAIL  = 3'b101
  } bus_state_e;

  // Core data-space request
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_req_s;

  // Port register view of one 8-bit port
  typedef struct packed {
    logic [7:0] out_val;
    logic [7:0] dir;
  } port_cfg_s;

endpackage : ext_mem_pkg

/* File: ext_sram_model.sv */
`timescale 1ns/1ns
module ext_sram_model (
  // Bus from controller
  input  wire logic       clk_i,
  input  wire logic       ale_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] ad_i,
  input  wire logic [7:0] ad_oe_i,
  input  wire logic [7:0] ah_i,
  input  wire logic [7:0] keep_val_i,
  input  wire logic       keep_en_i,
  input  wire logic [7:0] pullup_i,
  // Line level back to controller
  output logic      [7:0] lvl_o
);
  logic [7:0] lat_q;
  logic [7:0] last_q = 8'h00;
  logic [7:0] mem [65536];
  always_latch if (ale_i) lat_q <= ad_i;
  // No clock on the memory side: the bus is asynchronous
  always @* if (!wr_n_i) mem[{ah_i, lat_q}] = ad_i;
  always_ff @(posedge clk_i) last_q <= lvl_o;
  // Released lines float: pulled-up bits read one, others keep changing
  always_comb begin
    if (ad_oe_i == 8'hff) lvl_o = ad_i;
    else if (!rd_n_i) lvl_o = mem[{ah_i, lat_q}];
    else if (keep_en_i) lvl_o = keep_val_i;
    else lvl_o = pullup_i | ~last_q;
  end
endmodule : ext_sram_model

/* File: tb_external_memory_bus_controller.sv */
`timescale 1ns/1ns
module tb_external_memory_bus_controller;
  import ext_mem_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic req_i, next_mem_i, done_o, ext_hit_o, ad_keep_en_o;
  logic ctrl_pins_en_o, ale_o, rd_n_o, wr_n_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0] rdata_o, ad_i, ad_o, ad_oe_o, ad_pullup_o, ad_keep_val_o;
  logic [7:0] ah_o, ah_oe_o, q;
  mem_req_s req_data_i;
  port_cfg_s port_ad_i, port_ah_i;
  int n_fail, compares, lat, st;
  typedef struct { logic [7:0] a, b; logic [15:0] ad; int st, lat; } row_s;
  row_s rows[8] = '{'{8'h80, 8'h00, 16'h1234, 1, 5},
    '{8'hc0, 8'h00, 16'h4321, 2, 6}, '{8'h80, 8'h02, 16'h8000, 3, 7},
    '{8'hc0, 8'h02, 16'hffff, 3, 8}, '{8'h80, 8'h14, 16'h1100, 2, 6},
    '{8'h80, 8'h14, 16'h2000, 1, 5}, '{8'h80, 8'h7c, 16'hdfff, 3, 8},
    '{8'hc0, 8'h7c, 16'he000, 2, 6}};
  ext_mem_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .req_i(req_i), .req_data_i(req_data_i),
    .next_mem_i(next_mem_i), .done_o(done_o), .ext_hit_o(ext_hit_o),
    .rdata_o(rdata_o), .port_ad_i(port_ad_i), .port_ah_i(port_ah_i),
    .ad_i(ad_i), .ad_o(ad_o), .ad_oe_o(ad_oe_o), .ad_pullup_o(ad_pullup_o),
    .ad_keep_val_o(ad_keep_val_o), .ad_keep_en_o(ad_keep_en_o),
    .ah_o(ah_o), .ah_oe_o(ah_oe_o), .ctrl_pins_en_o(ctrl_pins_en_o),
    .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));
  ext_sram_model u_mem (.clk_i(clk_i), .ale_i(ale_o), .rd_n_i(rd_n_o),
    .wr_n_i(wr_n_o), .ad_i(ad_o), .ad_oe_i(ad_oe_o), .ah_i(ah_o),
    .keep_val_i(ad_keep_val_o), .keep_en_i(ad_keep_en_o),
    .pullup_i(ad_pullup_o), .lvl_o(ad_i));
  initial begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic fail(input string m);
    n_fail++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail
  task automatic chk8(input logic [7:0] g, e, input string m);
    compares++;
    if (g !== e) fail(m);
  endtask : chk8
  task automatic chki(input int g, e, input string m);
    compares++;
    if (g != e) fail(m);
  endtask : chki
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w;
    wb_adr_i <= a; wb_dat_i <= {24'h0, d};
    for (i = 0; i < 10 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
    if (i == 10) begin
      fail("bus timeout");
      close_out();
    end
    q = wb_dat_o[7:0];
    wb_cyc_i <= 0; wb_stb_i <= 0;
  endtask : wb
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [7:0] d, input logic nx);
    int i;
    @(posedge clk_i);
    req_i <= 1; req_data_i <= '{w, a, d}; next_mem_i <= nx;
    lat = 0; st = 0;
    for (i = 0; i < 20 && done_o !== 1'b1; i++) begin
      @(posedge clk_i);
      lat++;
      if (rd_n_o === 1'b0 || wr_n_o === 1'b0) st++;
    end
    if (i == 20) begin
      fail("access timeout");
      close_out();
    end
    req_i <= 0;
    repeat (2) @(posedge clk_i);
  endtask : acc
  initial begin
    n_fail = 0; compares = 0; rst_i = 1; req_i = 0; next_mem_i = 0;
    wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0; wb_adr_i = 0; wb_sel_i = 4'hf;
    wb_dat_i = 0; req_data_i = '0; port_ah_i = '0;
    port_ad_i = '{8'h0f, 8'h00};
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    foreach (rows[k]) begin
      wb(1, OFS_CTRL_A, rows[k].a);
      wb(1, OFS_CTRL_B, rows[k].b);
      acc(1, rows[k].ad, rows[k].ad[7:0] ^ 8'h5a, k[0]);
      chki(st, rows[k].st, "write strobe length");
      chki(lat, rows[k].lat, "write latency");
      acc(0, rows[k].ad, 8'h00, 1'b0);
      chki(st, rows[k].st, "read strobe length");
      chk8(rdata_o, rows[k].ad[7:0] ^ 8'h5a, "read data");
      chk8({7'h0, ext_hit_o}, 8'h01, "external hit");
      chk8(ah_oe_o, 8'hff, "high pins taken");
      $display("row %0d done", k);
    end
    wb(0, OFS_CTRL_B, 8'h00);
    chk8(q, 8'h7c, "control b readback");
    chk8(ad_pullup_o, 8'h0f, "pull-ups");
    acc(0, 16'h0100, 8'h00, 1'b1);
    chki(lat, 4, "internal latency");
    chki(st, 0, "internal strobe");
    chk8({7'h0, ext_hit_o}, 8'h00, "internal hit");
    $display("table and internal tests done");
    wb(1, OFS_CTRL_A, 8'h00);
    wb(1, OFS_SPECIAL, 8'h40);
    acc(0, 16'h2000, 8'h00, 1'b0);
    chki(lat, 2, "disabled latency");
    chki(st, 0, "disabled strobe");
    chk8(rdata_o, 8'h00, "no aliasing");
    chk8(ah_oe_o, 8'h00, "port directions back");
    chk8({7'h0, ad_keep_en_o}, 8'h01, "keeper while disabled");
    $display("disabled tests done");
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, OFS_CTRL_A, 8'h00);
    chk8(q, CTRL_A_RST, "control a reset");
    wb(0, OFS_CTRL_B, 8'h00);
    chk8(q, CTRL_B_RST, "control b reset");
    wb(1, 4'h2, 8'hff);
    wb(0, 4'h2, 8'h00);
    chk8(q, 8'h00, "unmapped read");
    wb(1, OFS_CTRL_A, 8'h80);
    wb(1, OFS_SPECIAL, 8'h08);
    repeat (2) @(posedge clk_i);
    chk8(ah_oe_o, 8'h7f, "one high pin released");
    wb(1, OFS_SPECIAL, 8'h30);
    repeat (2) @(posedge clk_i);
    chk8(ah_oe_o, 8'h03, "six high pins released");
    $display("reset and mask tests done");
    close_out();
  end
endmodule : tb_external_memory_bus_controller
